/* File: design/ltcm_params.svh */
`ifndef LTCM_PARAMS_SVH
`define LTCM_PARAMS_SVH

// clock and link timing
`define CLK_FREQ_HZ 50000000
`define POLL_TIMEOUT_MS 24
`define SIM_TIMEOUT_US 2
`define POLL_TIMEOUT_CYC (`POLL_TIMEOUT_MS * (`CLK_FREQ_HZ / 1000))
`define SIM_TIMEOUT_CYC (`SIM_TIMEOUT_US * (`CLK_FREQ_HZ / 1000000))
`define TMR_W 21

// register byte offsets
`define REG_CTRL 4'h0
`define REG_STATUS 4'h4
`define REG_CONFIG 4'h8

// test control fields
`define CTRL_RESET 32'h00000000
`define CTRL_WMASK 32'h0000e061
`define CTRL_SIM 0
`define CTRL_CDIS 5
`define CTRL_CFRC 6
`define CTRL_FIX_LO 8
`define CTRL_FIX_HI 11
`define CTRL_FIX_VAL 4'h3
`define CTRL_LSEL_LO 13
`define CTRL_LSEL_HI 15

// per-lane monitor slice layout
`define MON_SLICE_W 64
`define MON_TXD_LO 0
`define MON_TXK 8
`define MON_TXDET 9
`define MON_TXEI 10
`define MON_TXCMP 11
`define MON_RXPOL 12
`define MON_PD_LO 13
`define MON_RXD_LO 15
`define MON_RXK 23
`define MON_RXV 24
`define MON_USED_W 25

// reduced monitor source positions
`define N8_LO_SRC 0
`define N8_HI_SRC 88
`define N4_LO_SRC 320
`define N4_HI_SRC 408
`define WIDE_X8 128
`define WIDE_X4 512

`endif

/* File: design/ltcm_pkg.sv */
package ltcm_pkg;
	typedef enum {
		ST_DETECT,
		ST_POLL_ACTIVE,
		ST_COMPLIANCE,
		ST_CONFIG
	} link_state_t;
endpackage : ltcm_pkg

/* File: design/link_test_control_monitor.sv */
// Decided for this implementation: the register offsets and the Avalon-MM slave port.
`include "ltcm_params.svh"

module link_test_control_monitor #(
	parameter int LANES = 4,
	parameter bit NARROW = 1'b0,
	parameter int POLL_TIMEOUT_CYC = `POLL_TIMEOUT_CYC,
	parameter int SIM_TIMEOUT_CYC = `SIM_TIMEOUT_CYC
) (
	input wire logic CLK,
	input wire logic RST,
	input wire logic [3:0] AVS_ADDRESS,
	input wire logic AVS_READ,
	input wire logic AVS_WRITE,
	input wire logic [31:0] AVS_WRITEDATA,
	input wire logic [3:0] AVS_BYTEENABLE,
	output logic [31:0] AVS_READDATA,
	output logic AVS_WAITREQUEST,
	input wire logic RX_DETECTED,
	input wire logic [LANES-1:0] RX_EXIT_DET,
	input wire logic [8*LANES-1:0] TX_DATA,
	input wire logic [LANES-1:0] TX_DATAK,
	input wire logic [LANES-1:0] TX_DETECT_RX,
	input wire logic [LANES-1:0] TX_ELEC_IDLE,
	input wire logic [LANES-1:0] RX_POLARITY,
	input wire logic [2*LANES-1:0] POWER_DOWN,
	input wire logic [8*LANES-1:0] RX_DATA,
	input wire logic [LANES-1:0] RX_DATAK,
	input wire logic [LANES-1:0] RX_VALID,
	output logic SIM_MODE,
	output logic TX_COMPLIANCE,
	output logic [((LANES == 8) ? `WIDE_X8 : `WIDE_X4)-1:0] TEST_OUT,
	output logic [8:0] TEST_OUT_9
);
	import ltcm_pkg::*;

	localparam int WIDE_W = (LANES == 8) ? `WIDE_X8 : `WIDE_X4;
	localparam int SLICES = WIDE_W / `MON_SLICE_W;
	localparam int LO_SRC = (LANES == 8) ? `N8_LO_SRC : `N4_LO_SRC;
	localparam int HI_SRC = (LANES == 8) ? `N8_HI_SRC : `N4_HI_SRC;
	localparam int LW = (LANES > 1) ? $clog2(LANES) : 1;

	logic [31:0] ctrl_ff;
	logic ack_ff;
	logic [31:0] rdata_ff;
	link_state_t st_ff;
	logic [`TMR_W-1:0] tmr_ff;
	logic [WIDE_W-1:0] mon_ff;
	logic [8:0] mon9_ff;

	// bus decode
	wire req = AVS_READ | AVS_WRITE;
	wire sel_ctrl = (AVS_ADDRESS[3:2] == 2'(`REG_CTRL >> 2));
	wire sel_status = (AVS_ADDRESS[3:2] == 2'(`REG_STATUS >> 2));
	wire sel_config = (AVS_ADDRESS[3:2] == 2'(`REG_CONFIG >> 2));
	wire [31:0] be_mask = {{8{AVS_BYTEENABLE[3]}}, {8{AVS_BYTEENABLE[2]}},
		{8{AVS_BYTEENABLE[1]}}, {8{AVS_BYTEENABLE[0]}}};
	wire [31:0] wmask = be_mask & `CTRL_WMASK;
	wire do_write = AVS_WRITE & ack_ff & sel_ctrl;
	wire [31:0] nxt_ctrl = (ctrl_ff & ~wmask) | (AVS_WRITEDATA & wmask);

	// control fields
	wire sim_mode = ctrl_ff[`CTRL_SIM];
	wire cmp_dis = ctrl_ff[`CTRL_CDIS];
	wire cmp_frc = ctrl_ff[`CTRL_CFRC];
	wire [2:0] lane_sel = ctrl_ff[`CTRL_LSEL_HI:`CTRL_LSEL_LO];

	// read views
	wire [31:0] ctrl_view = ctrl_ff | ({28'h0000000, `CTRL_FIX_VAL} << `CTRL_FIX_LO);
	wire [7:0] exit_pad = 8'(RX_EXIT_DET);
	wire [31:0] status_view = {16'h0000, exit_pad, 4'h0,
		(st_ff == ST_COMPLIANCE), sim_mode, 2'(st_ff)};
	wire [31:0] config_view = {23'h000000, NARROW, 8'(LANES)};
	// unmapped reads give zero with the same single wait
	wire [31:0] nxt_rdata = !AVS_READ ? 32'h00000000 :
		sel_ctrl ? ctrl_view :
		sel_status ? status_view :
		sel_config ? config_view : 32'h00000000;

	assign AVS_WAITREQUEST = req & ~ack_ff;
	assign AVS_READDATA = rdata_ff;

	always_ff @(posedge CLK) begin
		if (RST) begin
			ack_ff <= 1'b0;
			rdata_ff <= 32'h00000000;
			ctrl_ff <= `CTRL_RESET;
		end else begin
			ack_ff <= req & ~ack_ff;
			if (req & ~ack_ff) begin
				rdata_ff <= nxt_rdata;
			end
			if (do_write) begin
				ctrl_ff <= nxt_ctrl;
			end
		end
	end

	// polling timer, shortened in simulation mode
	// compare with >= so a sim bit change mid-count still ends polling
	wire [`TMR_W-1:0] tmr_limit = sim_mode ? `TMR_W'(SIM_TIMEOUT_CYC - 1) :
		`TMR_W'(POLL_TIMEOUT_CYC - 1);
	wire timeout = (st_ff == ST_POLL_ACTIVE) && (tmr_ff >= tmr_limit);
	wire all_exit = &RX_EXIT_DET;
	wire any_exit = |RX_EXIT_DET;
	wire [`TMR_W-1:0] nxt_tmr = (st_ff == ST_POLL_ACTIVE && !timeout) ?
		tmr_ff + `TMR_W'(1) : '0;

	// disable is tested before force, so disable wins
	link_state_t nxt_st;
	always_comb begin
		nxt_st = st_ff;
		case (st_ff)
			ST_DETECT: begin
				if (RX_DETECTED) begin
					nxt_st = ST_POLL_ACTIVE;
				end
			end
			ST_POLL_ACTIVE: begin
				if (!RX_DETECTED) begin
					nxt_st = ST_DETECT;
				end else if (all_exit) begin
					nxt_st = ST_CONFIG;
				end else if (timeout) begin
					if (cmp_dis) begin
						nxt_st = any_exit ? ST_CONFIG : ST_DETECT;
					end else if (cmp_frc) begin
						nxt_st = ST_COMPLIANCE;
					end else begin
						nxt_st = any_exit ? ST_CONFIG : ST_COMPLIANCE;
					end
				end
			end
			ST_COMPLIANCE: begin
				if (cmp_dis || !RX_DETECTED) begin
					nxt_st = ST_DETECT;
				end
			end
			ST_CONFIG: begin
				if (!RX_DETECTED) begin
					nxt_st = ST_DETECT;
				end
			end
			default: begin
				nxt_st = ST_DETECT;
			end
		endcase
	end

	always_ff @(posedge CLK) begin
		if (RST) begin
			st_ff <= ST_DETECT;
			tmr_ff <= '0;
		end else begin
			st_ff <= nxt_st;
			tmr_ff <= nxt_tmr;
		end
	end

	wire in_cmp = (st_ff == ST_COMPLIANCE);
	assign SIM_MODE = sim_mode;
	assign TX_COMPLIANCE = in_cmp;

	// lane k of the monitor shows lane (sel + k) mod LANES, a sel of LANES or more counting as 0
	wire [LW-1:0] base_lane = (32'(lane_sel) < LANES) ? LW'(lane_sel) : '0;
	wire [WIDE_W-1:0] nxt_mon;

	genvar k;
	generate
		for (k = 0; k < SLICES; k++) begin : g_slice
			wire [LW:0] sum = {1'b0, base_lane} + (LW + 1)'(k % LANES);
			wire [LW-1:0] ln = (32'(sum) >= LANES) ? LW'(32'(sum) - LANES) : sum[LW-1:0];
			wire [`MON_USED_W-1:0] used = {
				RX_VALID[ln],
				RX_DATAK[ln],
				RX_DATA[8*ln +: 8],
				POWER_DOWN[2*ln +: 2],
				RX_POLARITY[ln],
				in_cmp,
				TX_ELEC_IDLE[ln],
				TX_DETECT_RX[ln],
				TX_DATAK[ln],
				TX_DATA[8*ln +: 8]
			};
			assign nxt_mon[k*`MON_SLICE_W +: `MON_SLICE_W] =
				NARROW ? '0 : {{(`MON_SLICE_W - `MON_USED_W){1'b0}}, used};
		end
	endgenerate

	// reduced view taken from the full map regardless of NARROW
	wire [WIDE_W-1:0] full_mon;
	generate
		for (k = 0; k < SLICES; k++) begin : g_full
			assign full_mon[k*`MON_SLICE_W +: `MON_SLICE_W] = {
				{(`MON_SLICE_W - `MON_USED_W){1'b0}}, g_slice[k].used};
		end
	endgenerate
	wire [8:0] nxt_mon9 = {full_mon[HI_SRC +: 4], full_mon[LO_SRC +: 5]};

	always_ff @(posedge CLK) begin
		if (RST) begin
			mon_ff <= '0;
			mon9_ff <= 9'h000;
		end else begin
			mon_ff <= nxt_mon;
			mon9_ff <= nxt_mon9;
		end
	end

	assign TEST_OUT = mon_ff;
	assign TEST_OUT_9 = mon9_ff;
endmodule : link_test_control_monitor

/* File: testbench/ltcm_props.sv */
module ltcm_props (
	input wire logic CLK,
	input wire logic RST,
	input wire logic [3:0] AVS_ADDRESS,
	input wire logic AVS_READ,
	input wire logic AVS_WRITE,
	input wire logic [31:0] AVS_WRITEDATA,
	input wire logic [3:0] AVS_BYTEENABLE,
	input wire logic AVS_WAITREQUEST,
	input wire logic RX_DETECTED,
	input wire logic SIM_MODE,
	input wire logic TX_COMPLIANCE,
	input wire logic [511:0] TEST_OUT,
	input wire logic [8:0] TEST_OUT_9
);
	timeunit 1ns;
	timeprecision 1ns;
	logic dis_ff;
	wire wr_ctrl = AVS_WRITE && !AVS_WAITREQUEST && AVS_ADDRESS[3:2] == 2'h0;
	always_ff @(posedge CLK) begin
		if (RST) dis_ff <= 1'b0;
		else if (wr_ctrl && AVS_BYTEENABLE[0]) dis_ff <= AVS_WRITEDATA[5];
	end
	default clocking cb @(posedge CLK); endclocking
	default disable iff (RST);
	sequence req_wait; (AVS_READ || AVS_WRITE) && AVS_WAITREQUEST; endsequence
	sequence ack_slot; !AVS_WAITREQUEST; endsequence
	chk_one_wait: assert property (req_wait |=> ack_slot) else $error("wait too long");
	chk_sim_source: assert property (wr_ctrl && AVS_BYTEENABLE[0] |=>
		SIM_MODE == $past(AVS_WRITEDATA[0])) else $error("sim bit");
	chk_compl_off: assert property (dis_ff |=> !TX_COMPLIANCE) else $error("compl on");
	chk_compl_entry: assert property ($rose(TX_COMPLIANCE) |->
		$past(RX_DETECTED) && !$past(dis_ff)) else $error("compl entry");
	chk_compl_bit: assert property (!$past(RST) |->
		TEST_OUT[11] == $past(TX_COMPLIANCE)) else $error("compl field");
	chk_resv_zero: assert property (TEST_OUT[63:25] == '0 && TEST_OUT[511:473] == '0)
		else $error("reserved");
	chk_wrap_slice: assert property (TEST_OUT[319:256] == TEST_OUT[63:0])
		else $error("wrap");
	chk_reduced_map: assert property (TEST_OUT_9 == {TEST_OUT[411:408], TEST_OUT[324:320]})
		else $error("reduced");
endmodule : ltcm_props
bind link_test_control_monitor ltcm_props i_ltcm_props (.*);

/* File: testbench/pipe_far_model.sv */
module pipe_far_model (
	input wire logic CLK,
	input wire logic EN,
	output logic [31:0] TX_DATA,
	output logic [3:0] TX_DATAK,
	output logic [3:0] TX_DETECT_RX,
	output logic [3:0] TX_ELEC_IDLE,
	output logic [3:0] RX_POLARITY,
	output logic [7:0] POWER_DOWN,
	output logic [31:0] RX_DATA,
	output logic [3:0] RX_DATAK,
	output logic [3:0] RX_VALID
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [15:0] cnt_ff = 16'h0;
	assign TX_DATA = {cnt_ff[7:0] ^ 8'h3c, cnt_ff[7:0] ^ 8'h5a, cnt_ff[7:0] ^ 8'h96, cnt_ff[7:0]};
	assign RX_DATA = ~{TX_DATA[15:0], TX_DATA[31:16]};
	assign {POWER_DOWN, TX_DATAK, TX_DETECT_RX, TX_ELEC_IDLE, RX_POLARITY, RX_DATAK, RX_VALID} =
		{cnt_ff * 16'h9e37, cnt_ff};
	always_ff @(posedge CLK) begin
		if (EN) cnt_ff <= cnt_ff + 16'h1;
	end
endmodule : pipe_far_model

/* File: testbench/link_test_control_monitor_test.sv */
module link_test_control_monitor_test;
	timeunit 1ns;
	timeprecision 1ns;
	logic CLK = 1'b0, RST = 1'b1, AVS_READ = 1'b0, AVS_WRITE = 1'b0, RX_DETECTED = 1'b0;
	logic EN = 1'b1, AVS_WAITREQUEST, SIM_MODE, TX_COMPLIANCE;
	logic [3:0] AVS_ADDRESS = 4'h0, AVS_BYTEENABLE = 4'h0, RX_EXIT_DET = 4'h1;
	logic [3:0] TX_DATAK, TX_DETECT_RX, TX_ELEC_IDLE, RX_POLARITY, RX_DATAK, RX_VALID;
	logic [31:0] AVS_WRITEDATA = 32'h0, AVS_READDATA, TX_DATA, RX_DATA, q;
	logic [7:0] POWER_DOWN;
	logic [511:0] TEST_OUT;
	logic [8:0] TEST_OUT_9;
	int n_mismatch = 0;
	int checked = 0;
	link_test_control_monitor #(.POLL_TIMEOUT_CYC(50), .SIM_TIMEOUT_CYC(10))
		i_link_test_control_monitor (.*);
	pipe_far_model i_pipe_far_model (.*);
	initial forever #10 CLK = ~CLK;
	task automatic print_verdict;
		$display("checked %0d n_mismatch %0d", checked, n_mismatch);
		if (n_mismatch == 0 && checked > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask : print_verdict
	task automatic cmp(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED %s exp %h seen %h", nm, exp, seen);
		end
	endtask : cmp
	task automatic acc(input logic w, input logic [3:0] a, input logic [31:0] d, input logic [3:0] b);
		int i;
		@(posedge CLK);
		AVS_WRITE <= w;
		AVS_READ <= !w;
		AVS_ADDRESS <= a;
		AVS_WRITEDATA <= d;
		AVS_BYTEENABLE <= b;
		for (i = 0; i < 9; i++) begin
			@(posedge CLK);
			if (!AVS_WAITREQUEST) break;
		end
		q = AVS_READDATA;
		AVS_WRITE <= 1'b0;
		AVS_READ <= 1'b0;
		if (i == 9) begin
			n_mismatch++;
			print_verdict();
		end
	endtask : acc
	task automatic wt(input int n);
		repeat (n) @(posedge CLK);
	endtask : wt
	initial begin
		wt(2);
		RST <= 1'b0;
		acc(1'b0, 4'h0, 32'h0, 4'hf);
		cmp("ctrl rst", q, 32'h300);
		acc(1'b1, 4'h0, 32'hffffffff, 4'hf);
		acc(1'b0, 4'h0, 32'h0, 4'hf);
		cmp("ctrl rw", q, 32'he361);
		acc(1'b1, 4'h0, 32'h0, 4'h2);
		acc(1'b0, 4'hc, 32'h0, 4'hf);
		cmp("unmapped", q, 32'h0);
		acc(1'b0, 4'h0, 32'h0, 4'hf);
		cmp("ctrl be", q, 32'h361);
		EN <= 1'b0;
		for (int s = 0; s < 4; s++) begin
			acc(1'b1, 4'h0, 32'(s) << 13, 4'hf);
			wt(2);
			cmp("txd", 32'(TEST_OUT[7:0]), 32'(TX_DATA[8*s+:8]));
			cmp("rx", TEST_OUT[46:15], 32'({RX_VALID[s], RX_DATAK[s], RX_DATA[8*s+:8]}));
			cmp("k", 32'(TEST_OUT[10:8]), 32'({TX_ELEC_IDLE[s], TX_DETECT_RX[s], TX_DATAK[s]}));
			cmp("pd", 32'(TEST_OUT[14:12]), 32'({POWER_DOWN[2*s+:2], RX_POLARITY[s]}));
			cmp("wide", 32'(TEST_OUT[263:256]), 32'(TX_DATA[8*s+:8]));
			cmp("nine", 32'(TEST_OUT_9), 32'({RX_VALID[(s+2)%4], TX_DATA[8*((s+1)%4)+:5]}));
		end
		EN <= 1'b1;
		acc(1'b1, 4'h0, 32'h40, 4'hf);
		RX_DETECTED <= 1'b1;
		wt(13);
		cmp("slow", 32'(TX_COMPLIANCE), 32'h0);
		wt(50);
		cmp("force", 32'(TX_COMPLIANCE), 32'h1);
		RX_DETECTED <= 1'b0;
		acc(1'b1, 4'h0, 32'h41, 4'hf);
		RX_DETECTED <= 1'b1;
		wt(13);
		cmp("fast", 32'(TX_COMPLIANCE), 32'h1);
		acc(1'b1, 4'h0, 32'h61, 4'hf);
		wt(2);
		cmp("off", 32'(TX_COMPLIANCE), 32'h0);
		wt(13);
		cmp("never", 32'(TX_COMPLIANCE), 32'h0);
		acc(1'b1, 4'h0, 32'h0, 4'hf);
		print_verdict();
	end
endmodule : link_test_control_monitor_test
